// File: hdl/branch_skip_load_store_exec.sv
// Control-flow and data-transfer execution unit of an 8-bit core.
// Assumes a decoder that presents one op with its operand values, a
// register file beside it and a data memory with same-cycle read data.
//
// Function
// - Indirect call jumps to ptr_three, high bits zero, pushes return, 2/3 cycles.
// - Equal compare skips next instruction (PC+2 or 3) in 1/2/3 cycles.
// - Register bit skips test the chosen bit clear or set, 1/2/3 cycles.
// - I/O bit skips test a low I/O bit clear or set, 1/2/3 cycles.
// - Flag branches test flag s and jump to PC+k+1 in 1/2 cycles.
// - Signed branches test negative XOR overflow for zero or one.
// - Unsigned branches behave exactly as carry clear and carry set branches.
// - Interrupt-state branches test global interrupt enable one or zero.
// - Branches exist on Z, C, N, H, T, V set and clear, 1/2 cycles.
// - Absolute read loads a byte from address k, three cycles.
// - Absolute write stores a register byte at address k, two cycles.
// - Pointer read with post-increment loads then bumps pointer, two cycles.
// - Pointer read with pre-decrement drops pointer first, then loads.
// - Offset fetch reads pointer plus q, pointer unchanged, two cycles.
// - Pointer write with post-increment stores then bumps pointer, one cycle.
// - Pointer write with pre-decrement drops pointer then stores, one cycle.
`include "bsls_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module branch_skip_load_store_exec (
  input wire logic CORE_CLK,
  input wire logic RESET,
  input wire logic OP_VALID,
  output logic OP_READY,
  input wire bsls_pkg::op_t OP_CODE,
  input wire bsls_pkg::src_t OP_SRC,
  input wire logic [2:0] OP_SEL,
  input wire logic [4:0] OP_DST,
  input wire logic [15:0] OP_IMM,
  input wire logic [7:0] OP_RD_VAL,
  input wire logic [7:0] OP_RR_VAL,
  input wire logic [15:0] OP_RR_PAIR,
  input wire logic NEXT_TWO_WORD,
  input wire logic [7:0] IO_BYTE,
  input wire logic [15:0] PTR_ONE,
  input wire logic [15:0] PTR_TWO,
  input wire logic [15:0] PTR_THREE,
  output logic REG_WE,
  output logic REG_PAIR,
  output logic [4:0] REG_IDX,
  output logic [15:0] REG_WDATA,
  output logic PTR_WE,
  output logic [1:0] PTR_IDX,
  output logic [15:0] PTR_WDATA,
  output logic MEM_WE,
  output logic MEM_RE,
  output logic [15:0] MEM_ADDR,
  output logic [7:0] MEM_WDATA,
  input wire logic [7:0] MEM_RDATA,
  input wire logic FLAG_WE,
  input wire logic [7:0] FLAG_WDATA,
  output logic [7:0] FLAGS,
  output logic [21:0] PC,
  output logic [15:0] SP
);

  // ****************************************************************
  // State
  // ****************************************************************
  bsls_pkg::state_t state_q;
  bsls_pkg::state_t state_d;
  bsls_pkg::op_t op_q;
  logic [2:0] step_q;
  logic [2:0] len_q;
  logic [4:0] dst_q;
  logic [15:0] eff_q;
  logic [7:0] wdat_q;
  logic [21:0] ret_q;
  logic [15:0] pop_q;
  logic [21:0] pc_q;
  logic [15:0] sp_q;
  logic [7:0] flag_q;

  // ****************************************************************
  // Decode of the offered op
  // ****************************************************************
  wire logic accept;
  wire logic in_indirect_call_op;
  wire logic in_call;
  wire logic in_ret;
  wire logic in_cmp;
  wire logic in_branch;
  wire logic in_skip;
  wire logic in_absr;
  wire logic in_absw;
  wire logic in_pread;
  wire logic in_inc;
  wire logic in_dec;
  wire logic in_ofs;
  wire logic in_copy;
  wire logic two_word;
  wire logic fbit;
  wire logic br_cond;
  wire logic skip_cond;
  wire logic br_taken;
  wire logic sk_taken;
  wire logic [2:0] len_new;

  assign accept = OP_VALID & OP_READY;
  assign in_indirect_call_op = OP_CODE == bsls_pkg::OP_INDIRECT_CALL;
  assign in_call = OP_CODE == bsls_pkg::OP_ABS_CALL;
  assign in_ret = (OP_CODE == bsls_pkg::OP_SUB_EXIT) |
                  (OP_CODE == bsls_pkg::OP_INT_EXIT);
  assign in_cmp = (OP_CODE == bsls_pkg::OP_CMP_REGS) |
                  (OP_CODE == bsls_pkg::OP_CMP_CARRY) |
                  (OP_CODE == bsls_pkg::OP_CMP_IMM);
  assign in_branch = (OP_CODE >= bsls_pkg::OP_BR_SET) &
                     (OP_CODE <= bsls_pkg::OP_BR_ID);
  assign in_skip = (OP_CODE == bsls_pkg::OP_EQ_SKIP) |
                   ((OP_CODE >= bsls_pkg::OP_SKIP_RBC) &
                    (OP_CODE <= bsls_pkg::OP_SKIP_IOS));
  assign in_absr = OP_CODE == bsls_pkg::OP_ABS_READ;
  assign in_absw = OP_CODE == bsls_pkg::OP_ABS_WRITE;
  assign in_pread = (OP_CODE >= bsls_pkg::OP_PTR_READ) &
                    (OP_CODE <= bsls_pkg::OP_OFS_READ);
  assign in_inc = (OP_CODE == bsls_pkg::OP_PTR_READ_INC) |
                  (OP_CODE == bsls_pkg::OP_PTR_WRITE_INC);
  assign in_dec = (OP_CODE == bsls_pkg::OP_PTR_READ_DEC) |
                  (OP_CODE == bsls_pkg::OP_PTR_WRITE_DEC);
  assign in_ofs = OP_CODE == bsls_pkg::OP_OFS_READ;
  assign in_copy = (OP_CODE == bsls_pkg::OP_REG_COPY) |
                   (OP_CODE == bsls_pkg::OP_PAIR_COPY);
  assign two_word = in_call | in_absr | in_absw;

  // ****************************************************************
  // Branch and skip conditions
  // ****************************************************************
  assign fbit = flag_q[OP_SEL];
  assign br_cond =
    (OP_CODE == bsls_pkg::OP_BR_SET) ? fbit :
    (OP_CODE == bsls_pkg::OP_BR_CLR) ? ~fbit :
    (OP_CODE == bsls_pkg::OP_BR_SGE) ?
      ~(flag_q[`FLAG_N] ^ flag_q[`FLAG_V]) :
    (OP_CODE == bsls_pkg::OP_BR_SLT) ?
      (flag_q[`FLAG_N] ^ flag_q[`FLAG_V]) :
    (OP_CODE == bsls_pkg::OP_BR_UGE) ? ~flag_q[`FLAG_C] :
    (OP_CODE == bsls_pkg::OP_BR_ULT) ? flag_q[`FLAG_C] :
    (OP_CODE == bsls_pkg::OP_BR_IE) ? flag_q[`FLAG_I] :
    ~flag_q[`FLAG_I];
  assign skip_cond =
    (OP_CODE == bsls_pkg::OP_EQ_SKIP) ? (OP_RD_VAL == OP_RR_VAL) :
    (OP_CODE == bsls_pkg::OP_SKIP_RBC) ? ~OP_RR_VAL[OP_SEL] :
    (OP_CODE == bsls_pkg::OP_SKIP_RBS) ? OP_RR_VAL[OP_SEL] :
    (OP_CODE == bsls_pkg::OP_SKIP_IOC) ? ~IO_BYTE[OP_SEL] :
    IO_BYTE[OP_SEL];
  assign br_taken = in_branch & br_cond;
  assign sk_taken = in_skip & skip_cond;

  // ****************************************************************
  // Occupancy of the offered op in cycles
  // ****************************************************************
  assign len_new =
    in_indirect_call_op ? `LEN_INDIRECT_CALL_OP :
    in_call ? `LEN_CALL :
    in_ret ? `LEN_RET :
    in_absr ? `LEN_ABS_READ :
    in_absw ? `LEN_ABS_WRITE :
    in_pread ? `LEN_PTR_READ :
    br_taken ? `LEN_BR_TAKEN :
    sk_taken ? (NEXT_TWO_WORD ? `LEN_SKIP_TWO : `LEN_SKIP_ONE) :
    `LEN_SINGLE;

  // ****************************************************************
  // Program counter, addresses and pointer arithmetic
  // ****************************************************************
  wire logic [15:0] ptr_cur;
  wire logic [15:0] ptr_inc;
  wire logic [15:0] ptr_dec;
  wire logic [15:0] eff_new;
  wire logic [21:0] pc_seq;
  wire logic [21:0] pc_new;
  wire logic [21:0] k_ext;

  assign ptr_cur = (OP_SEL[1:0] == `PTR_SEL_ONE) ? PTR_ONE :
                   (OP_SEL[1:0] == `PTR_SEL_TWO) ? PTR_TWO : PTR_THREE;
  assign ptr_inc = ptr_cur + 16'h0001;
  assign ptr_dec = ptr_cur - 16'h0001;
  assign eff_new = (in_absr | in_absw) ? OP_IMM :
                   in_dec ? ptr_dec :
                   in_ofs ? ptr_cur + {10'h000, OP_IMM[5:0]} :
                   ptr_cur;
  assign k_ext = {{6{OP_IMM[15]}}, OP_IMM};
  assign pc_seq = pc_q + (two_word ? 22'h000002 : 22'h000001);
  assign pc_new =
    in_indirect_call_op ? {6'h00, PTR_THREE} :
    in_call ? {6'h00, OP_IMM} :
    in_ret ? pc_q :
    br_taken ? pc_q + k_ext + 22'h000001 :
    sk_taken ? pc_q + (NEXT_TWO_WORD ? 22'h000003 : 22'h000002) :
    pc_seq;

  // ****************************************************************
  // Memory step issue: a push or pop strobes the port in its steps 1..PC_BYTES, a load or store in step 1 only
  // ****************************************************************
  wire logic cont;
  wire logic issue;
  wire logic [2:0] ns;
  wire bsls_pkg::op_t cur_op;
  wire logic [21:0] cur_ret;
  wire logic cur_push;
  wire logic cur_pop;
  wire logic cur_load;
  wire logic cur_store;
  wire logic we_d;
  wire logic re_d;
  wire logic [7:0] push_byte;
  wire logic q_load;
  wire logic q_pop;
  wire logic pop_last;
  wire logic [23:0] pop_full;

  assign cont = (state_q == bsls_pkg::ST_RUN) & (step_q < len_q);
  assign issue = accept | cont;
  assign ns = accept ? 3'h1 : step_q + 3'h1;
  assign cur_op = accept ? OP_CODE : op_q;
  assign cur_ret = accept ? pc_seq : ret_q;
  assign cur_push = (cur_op == bsls_pkg::OP_INDIRECT_CALL) |
                    (cur_op == bsls_pkg::OP_ABS_CALL);
  assign cur_pop = (cur_op == bsls_pkg::OP_SUB_EXIT) |
                   (cur_op == bsls_pkg::OP_INT_EXIT);
  assign cur_load = (cur_op == bsls_pkg::OP_ABS_READ) |
                    ((cur_op >= bsls_pkg::OP_PTR_READ) &
                     (cur_op <= bsls_pkg::OP_OFS_READ));
  assign cur_store = (cur_op == bsls_pkg::OP_ABS_WRITE) |
                     ((cur_op >= bsls_pkg::OP_PTR_WRITE) &
                      (cur_op <= bsls_pkg::OP_PTR_WRITE_DEC));
  assign we_d = issue & ((cur_push & (ns <= `PC_BYTES)) |
                         (cur_store & (ns == 3'h1)));
  assign re_d = issue & ((cur_pop & (ns <= `PC_BYTES)) |
                         (cur_load & (ns == 3'h1)));
  // Low byte goes first so the pops rebuild the address high to low
  assign push_byte = (ns == 3'h1) ? cur_ret[7:0] :
                     (ns == 3'h2) ? cur_ret[15:8] : {2'h0, cur_ret[21:16]};
  assign q_load = (op_q == bsls_pkg::OP_ABS_READ) |
                  ((op_q >= bsls_pkg::OP_PTR_READ) &
                   (op_q <= bsls_pkg::OP_OFS_READ));
  assign q_pop = (op_q == bsls_pkg::OP_SUB_EXIT) |
                 (op_q == bsls_pkg::OP_INT_EXIT);
  assign pop_last = MEM_RE & q_pop & (step_q == `PC_BYTES);
  assign pop_full = {pop_q, MEM_RDATA};

  // ****************************************************************
  // Compare flags
  // ****************************************************************
  logic cf_c;
  logic cf_z;
  logic cf_n;
  logic cf_v;
  logic cf_s;
  logic cf_h;

  sub_flag_unit u_sub (
    .a(OP_RD_VAL),
    .b((OP_CODE == bsls_pkg::OP_CMP_IMM) ? OP_IMM[7:0] : OP_RR_VAL),
    .carry_in(flag_q[`FLAG_C]),
    .use_carry(OP_CODE == bsls_pkg::OP_CMP_CARRY),
    .z_old(flag_q[`FLAG_Z]),
    .c(cf_c),
    .z(cf_z),
    .n(cf_n),
    .v(cf_v),
    .s(cf_s),
    .h(cf_h)
  );

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  assign OP_READY = (state_q == bsls_pkg::ST_IDLE) | (step_q == len_q);
  assign state_d = (accept | cont) ? bsls_pkg::ST_RUN : bsls_pkg::ST_IDLE;

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      state_q <= bsls_pkg::ST_IDLE;
      op_q <= bsls_pkg::OP_NOP;
      step_q <= 3'h0;
      len_q <= 3'h0;
      dst_q <= 5'h00;
      eff_q <= 16'h0000;
      wdat_q <= 8'h00;
      ret_q <= 22'h000000;
    end else begin
      state_q <= state_d;
      step_q <= issue ? ns : step_q;
      if (accept) begin
        op_q <= OP_CODE;
        len_q <= len_new;
        dst_q <= OP_DST;
        eff_q <= eff_new;
        wdat_q <= OP_RR_VAL;
        ret_q <= pc_seq;
      end
    end
  end

  // ****************************************************************
  // Data memory port and stack pointer
  // ****************************************************************
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      MEM_WE <= 1'b0;
      MEM_RE <= 1'b0;
      MEM_ADDR <= 16'h0000;
      MEM_WDATA <= 8'h00;
      sp_q <= `SP_RESET;
    end else begin
      MEM_WE <= we_d;
      MEM_RE <= re_d;
      MEM_ADDR <= cur_push ? sp_q : cur_pop ? sp_q + 16'h0001 :
                  (accept ? eff_new : eff_q);
      MEM_WDATA <= cur_push ? push_byte : (accept ? OP_RR_VAL : wdat_q);
      if (we_d & cur_push) begin
        sp_q <= sp_q - 16'h0001;
      end else if (re_d & cur_pop) begin
        sp_q <= sp_q + 16'h0001;
      end
    end
  end

  // ****************************************************************
  // Register and pointer write-back
  // ****************************************************************
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      REG_WE <= 1'b0;
      REG_PAIR <= 1'b0;
      REG_IDX <= 5'h00;
      REG_WDATA <= 16'h0000;
      PTR_WE <= 1'b0;
      PTR_IDX <= 2'h0;
      PTR_WDATA <= 16'h0000;
    end else begin
      REG_WE <= (accept & in_copy) | (MEM_RE & q_load);
      REG_PAIR <= accept & (OP_CODE == bsls_pkg::OP_PAIR_COPY);
      if (accept & in_copy) begin
        REG_IDX <= OP_DST;
        REG_WDATA <= (OP_CODE == bsls_pkg::OP_PAIR_COPY) ? OP_RR_PAIR :
                     (OP_SRC == bsls_pkg::SRC_IMM) ? {8'h00, OP_IMM[7:0]} :
                     {8'h00, OP_RR_VAL};
      end else if (MEM_RE & q_load) begin
        REG_IDX <= dst_q;
        REG_WDATA <= {8'h00, MEM_RDATA};
      end
      PTR_WE <= accept & (in_inc | in_dec);
      if (accept & (in_inc | in_dec)) begin
        PTR_IDX <= OP_SEL[1:0];
        PTR_WDATA <= in_inc ? ptr_inc : ptr_dec;
      end
    end
  end

  // ****************************************************************
  // Program counter and flag register
  // ****************************************************************
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      pc_q <= `PC_RESET;
      pop_q <= 16'h0000;
      flag_q <= `FLAG_RESET;
    end else begin
      if (accept) begin
        pc_q <= pc_new;
        pop_q <= 16'h0000;
      end else if (pop_last) begin
        pc_q <= pop_full[21:0];
      end else if (MEM_RE & q_pop) begin
        pop_q <= {pop_q[7:0], MEM_RDATA};
      end
      // Hardware updates outrank a same-cycle external flag write
      if (accept & in_cmp) begin
        flag_q <= {flag_q[`FLAG_I], flag_q[`FLAG_T], cf_h, cf_s,
                   cf_v, cf_n, cf_z, cf_c};
      end else if (pop_last & (op_q == bsls_pkg::OP_INT_EXIT)) begin
        flag_q[`FLAG_I] <= 1'b1;
      end else if (FLAG_WE) begin
        flag_q <= FLAG_WDATA;
      end
    end
  end

  assign PC = pc_q;
  assign SP = sp_q;
  assign FLAGS = flag_q;

endmodule : branch_skip_load_store_exec
`default_nettype wire

// File: hdl/bsls_defines.svh
// Constants of the branch, skip, load and store execution unit.
// Assumes inclusion by bare name from every file that needs a figure.
`ifndef BSLS_DEFINES_SVH
`define BSLS_DEFINES_SVH

// ****************************************************************
// Flag register bit positions
// ****************************************************************
`define FLAG_C 0
`define FLAG_Z 1
`define FLAG_N 2
`define FLAG_V 3
`define FLAG_S 4
`define FLAG_H 5
`define FLAG_T 6
`define FLAG_I 7

// ****************************************************************
// Reset values
// ****************************************************************
`define PC_RESET 22'h000000
`define SP_RESET 16'h3fff
`define FLAG_RESET 8'h00

// ****************************************************************
// Pointer selection codes on OP_SEL[1:0]
// ****************************************************************
`define PTR_SEL_ONE 2'h0
`define PTR_SEL_TWO 2'h1
`define PTR_SEL_THREE 2'h2

// ****************************************************************
// Timing counts in core clock cycles
// ****************************************************************
// Bytes of return address moved per call or return: 2 or 3
`define PC_BYTES 3'h2
`define LEN_SINGLE 3'h1
`define LEN_BR_TAKEN 3'h2
`define LEN_SKIP_ONE 3'h2
`define LEN_SKIP_TWO 3'h3
`define LEN_INDIRECT_CALL_OP (`PC_BYTES)
`define LEN_CALL (`PC_BYTES + 3'h1)
`define LEN_RET (`PC_BYTES + 3'h2)
`define LEN_ABS_READ 3'h3
`define LEN_ABS_WRITE 3'h2
`define LEN_PTR_READ 3'h2

`endif

// File: hdl/bsls_pkg.sv
// Types of the branch, skip, load and store execution unit.
// Assumes nothing beyond a SystemVerilog compiler.
package bsls_pkg;

  // ****************************************************************
  // Decoded operations
  // ****************************************************************
  typedef enum logic [4:0] {
    OP_NOP = 5'h00,
    OP_INDIRECT_CALL = 5'h01,
    OP_ABS_CALL = 5'h02,
    OP_SUB_EXIT = 5'h03,
    OP_INT_EXIT = 5'h04,
    OP_EQ_SKIP = 5'h05,
    OP_CMP_REGS = 5'h06,
    OP_CMP_CARRY = 5'h07,
    OP_CMP_IMM = 5'h08,
    OP_SKIP_RBC = 5'h09,
    OP_SKIP_RBS = 5'h0a,
    OP_SKIP_IOC = 5'h0b,
    OP_SKIP_IOS = 5'h0c,
    OP_BR_SET = 5'h0d,
    OP_BR_CLR = 5'h0e,
    OP_BR_SGE = 5'h0f,
    OP_BR_SLT = 5'h10,
    OP_BR_UGE = 5'h11,
    OP_BR_ULT = 5'h12,
    OP_BR_IE = 5'h13,
    OP_BR_ID = 5'h14,
    OP_ABS_READ = 5'h15,
    OP_ABS_WRITE = 5'h16,
    OP_PTR_READ = 5'h17,
    OP_PTR_READ_INC = 5'h18,
    OP_PTR_READ_DEC = 5'h19,
    OP_OFS_READ = 5'h1a,
    OP_PTR_WRITE = 5'h1b,
    OP_PTR_WRITE_INC = 5'h1c,
    OP_PTR_WRITE_DEC = 5'h1d,
    OP_REG_COPY = 5'h1e,
    OP_PAIR_COPY = 5'h1f
  } op_t;

  // Constant loads reuse the register copy path with OP_IMM as source
  typedef enum logic [1:0] {
    SRC_REG = 2'h0,
    SRC_IMM = 2'h1
  } src_t;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_RUN = 1'b1
  } state_t;

endpackage : bsls_pkg

// File: hdl/sub_flag_unit.sv
// Subtract-for-flags unit used by the compare operations.
// Assumes operands are stable in the cycle the compare is accepted.
`timescale 1ns/1ps
`default_nettype none
module sub_flag_unit (
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire logic carry_in,
  input wire logic use_carry,
  input wire logic z_old,
  output logic c,
  output logic z,
  output logic n,
  output logic v,
  output logic s,
  output logic h
);

  // ****************************************************************
  // Subtraction, result kept only for the flags
  // ****************************************************************
  logic [8:0] diff;
  logic [7:0] r;

  assign diff = {1'b0, a} - {1'b0, b} - {8'h00, carry_in & use_carry};
  assign r = diff[7:0];
  assign c = diff[8];
  // With carry in, zero only survives if it was already set
  assign z = (r == 8'h00) & (z_old | ~use_carry);
  assign n = r[7];
  assign v = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
  assign s = n ^ v;
  assign h = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);

endmodule : sub_flag_unit
`default_nettype wire

// File: verification/bsls_asserts.sv
// Port-level checker of the branch, skip, load and store unit.
// Assumes binding onto the top module and the shared timing defines.
`include "bsls_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module bsls_asserts (
  input wire logic CORE_CLK,
  input wire logic RESET,
  input wire logic OP_VALID,
  input wire logic OP_READY,
  input wire bsls_pkg::op_t OP_CODE,
  input wire logic [2:0] OP_SEL,
  input wire logic [15:0] OP_IMM,
  input wire logic [7:0] OP_RD_VAL,
  input wire logic [7:0] OP_RR_VAL,
  input wire logic NEXT_TWO_WORD,
  input wire logic [15:0] PTR_TWO,
  input wire logic [15:0] PTR_THREE,
  input wire logic REG_WE,
  input wire logic PTR_WE,
  input wire logic [15:0] PTR_WDATA,
  input wire logic MEM_WE,
  input wire logic MEM_RE,
  input wire logic [15:0] MEM_ADDR,
  input wire logic [7:0] FLAGS,
  input wire logic [21:0] PC,
  input wire logic [15:0] SP
);
  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RESET);
  wire logic take = OP_VALID && OP_READY;
  sequence s_len2;
    !OP_READY ##1 OP_READY;
  endsequence
  sequence s_len3;
    !OP_READY [*2] ##1 OP_READY;
  endsequence
  // Offset is already sign-extended to 16 bits; widen it to the PC
  sequence s_rel_jump;
    PC == $past(PC) + {{6{$past(OP_IMM[15])}}, $past(OP_IMM)} + 22'h1;
  endsequence
  chk_reset_state: assert property ($fell(RESET) |-> PC == 22'h000000
    && SP == 16'h3fff && FLAGS == 8'h00) else $error("reset state");
  chk_flag_taken: assert property (take
    && OP_CODE == bsls_pkg::OP_BR_SET && FLAGS[OP_SEL]
    |=> s_rel_jump ##0 s_len2) else $error("flag branch");
  chk_flag_skip: assert property (take
    && OP_CODE == bsls_pkg::OP_BR_CLR && FLAGS[OP_SEL]
    |=> PC == $past(PC) + 22'h1 && OP_READY) else $error("flag no branch");
  chk_signed_ge: assert property (take
    && OP_CODE == bsls_pkg::OP_BR_SGE
    && !(FLAGS[`FLAG_N] ^ FLAGS[`FLAG_V]) |=> s_rel_jump ##0 s_len2)
    else $error("signed branch");
  chk_unsigned_lt: assert property (take
    && OP_CODE == bsls_pkg::OP_BR_ULT && !FLAGS[`FLAG_C]
    |=> PC == $past(PC) + 22'h1 && OP_READY) else $error("unsigned branch");
  chk_skip_two: assert property (take
    && OP_CODE == bsls_pkg::OP_EQ_SKIP
    && OP_RD_VAL == OP_RR_VAL && NEXT_TWO_WORD
    |=> PC == $past(PC) + 22'h3 ##0 s_len3) else $error("equal skip");
  chk_ptr_inc: assert property (take
    && OP_CODE == bsls_pkg::OP_PTR_READ_INC
    && OP_SEL[1:0] == 2'h1 |=> MEM_RE && MEM_ADDR == $past(PTR_TWO)
    && PTR_WE && PTR_WDATA == $past(PTR_TWO) + 16'h1 ##1 REG_WE)
    else $error("post-increment read");
  chk_store_dec: assert property (take
    && OP_CODE == bsls_pkg::OP_PTR_WRITE_DEC && OP_SEL[1:0] == 2'h2
    |=> MEM_WE && MEM_ADDR == $past(PTR_THREE) - 16'h1 && OP_READY)
    else $error("pre-decrement write");
  chk_indirect_call_op_jump: assert property (take
    && OP_CODE == bsls_pkg::OP_INDIRECT_CALL
    |=> PC == {6'h00, $past(PTR_THREE)} && !OP_READY
    ##1 SP == $past(SP, 2) - 16'h2 && OP_READY) else $error("indirect call");
  chk_cmp_equal: assert property (take
    && OP_CODE == bsls_pkg::OP_CMP_REGS && OP_RD_VAL == OP_RR_VAL
    |=> FLAGS[`FLAG_Z] && !FLAGS[`FLAG_C] && OP_READY)
    else $error("compare equal");
endmodule : bsls_asserts
bind branch_skip_load_store_exec bsls_asserts bsls_asserts_inst (
  .CORE_CLK(CORE_CLK), .RESET(RESET), .OP_VALID(OP_VALID),
  .OP_READY(OP_READY), .OP_CODE(OP_CODE), .OP_SEL(OP_SEL),
  .OP_IMM(OP_IMM), .OP_RD_VAL(OP_RD_VAL), .OP_RR_VAL(OP_RR_VAL),
  .NEXT_TWO_WORD(NEXT_TWO_WORD), .PTR_TWO(PTR_TWO),
  .PTR_THREE(PTR_THREE), .REG_WE(REG_WE), .PTR_WE(PTR_WE),
  .PTR_WDATA(PTR_WDATA), .MEM_WE(MEM_WE), .MEM_RE(MEM_RE),
  .MEM_ADDR(MEM_ADDR), .FLAGS(FLAGS), .PC(PC), .SP(SP));
`default_nettype wire

// File: verification/branch_skip_load_store_exec_test.sv
// Directed testbench of the branch, skip, load and store unit.
// Assumes the bound checker; memory read data is a fixed input.
`timescale 1ns/1ps
`default_nettype none
module branch_skip_load_store_exec_test;
  logic CORE_CLK = 1'b0, RESET = 1'b1, OP_VALID = 1'b0, NEXT_TWO_WORD = 1'b0;
  bsls_pkg::op_t OP_CODE = bsls_pkg::OP_NOP;
  bsls_pkg::src_t OP_SRC = bsls_pkg::SRC_REG;
  logic [2:0] OP_SEL = 3'h0;
  logic [4:0] OP_DST = 5'h10, REG_IDX;
  logic [15:0] OP_IMM = 16'h0, OP_RR_PAIR = 16'hbeef, PTR_ONE = 16'h0080;
  logic [15:0] PTR_TWO = 16'h0100, PTR_THREE = 16'h0200;
  logic [7:0] OP_RD_VAL = 8'h0, OP_RR_VAL = 8'h0, IO_BYTE = 8'h08;
  logic [7:0] MEM_RDATA = 8'h5a, FLAG_WDATA = 8'h0, FLAGS, MEM_WDATA;
  logic FLAG_WE = 1'b0, OP_READY, REG_WE, REG_PAIR, PTR_WE, MEM_WE, MEM_RE;
  logic [15:0] REG_WDATA, PTR_WDATA, MEM_ADDR, SP;
  logic [1:0] PTR_IDX;
  logic [21:0] PC, pc_exp = 22'h0;
  int failures = 0;
  int cmp_count = 0;
`define CHECK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
  $display("ERROR %s exp %h got %h", nm, e, g); failures++; end end
  branch_skip_load_store_exec branch_skip_load_store_exec_inst (.*);
  always #2 CORE_CLK = ~CORE_CLK;
  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Waits for room, offers one op, returns in the cycle after accept
  task automatic issue(input bsls_pkg::op_t op, input logic [2:0] sel,
      input logic [15:0] imm);
    int n;
    n = 0;
    @(negedge CORE_CLK);
    while (OP_READY !== 1'b1 && n < 8) begin
      @(negedge CORE_CLK);
      n++;
    end
    if (n == 8) failures++;
    OP_CODE = op;
    OP_SEL = sel;
    OP_IMM = imm;
    OP_VALID = 1'b1;
    @(negedge CORE_CLK);
    OP_VALID = 1'b0;
  endtask : issue
  task automatic jump(input bsls_pkg::op_t op, input logic [2:0] sel,
      input logic [15:0] imm, input logic taken, input logic [21:0] inc);
    issue(op, sel, imm);
    pc_exp = pc_exp + inc + (taken ? {{6{imm[15]}}, imm} : 22'h0);
    `CHECK("pc", pc_exp, PC)
    `CHECK("ready", !taken, OP_READY)
  endtask : jump
  task automatic complete_run;
    if (failures == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : complete_run
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_branch;
    @(negedge CORE_CLK);
    FLAG_WE = 1'b1;
    FLAG_WDATA = 8'h02;
    @(negedge CORE_CLK);
    FLAG_WE = 1'b0;
    jump(bsls_pkg::OP_BR_SET, 3'h1, 16'h0005, 1'b1, 22'h1);
    jump(bsls_pkg::OP_BR_CLR, 3'h1, 16'h0005, 1'b0, 22'h1);
    jump(bsls_pkg::OP_BR_SGE, 3'h0, 16'hfffe, 1'b1, 22'h1);
    jump(bsls_pkg::OP_BR_SLT, 3'h0, 16'h0003, 1'b0, 22'h1);
    jump(bsls_pkg::OP_BR_UGE, 3'h0, 16'h0004, 1'b1, 22'h1);
    jump(bsls_pkg::OP_BR_ULT, 3'h0, 16'h0004, 1'b0, 22'h1);
    jump(bsls_pkg::OP_BR_IE, 3'h0, 16'h0002, 1'b0, 22'h1);
    jump(bsls_pkg::OP_BR_ID, 3'h0, 16'h0002, 1'b1, 22'h1);
    for (int s = 0; s < 8; s++) begin
      jump(bsls_pkg::OP_BR_CLR, s[2:0], 16'h0001, s != 1, 22'h1);
    end
  endtask : t_branch
  task automatic t_skip;
    OP_RD_VAL = 8'h3c;
    OP_RR_VAL = 8'h3c;
    NEXT_TWO_WORD = 1'b1;
    jump(bsls_pkg::OP_EQ_SKIP, 3'h0, 16'h0, 1'b1, 22'h3);
    @(negedge CORE_CLK);
    `CHECK("ready", 1'b0, OP_READY)
    NEXT_TWO_WORD = 1'b0;
    jump(bsls_pkg::OP_SKIP_IOS, 3'h3, 16'h0, 1'b1, 22'h2);
    jump(bsls_pkg::OP_SKIP_IOC, 3'h3, 16'h0, 1'b0, 22'h1);
    jump(bsls_pkg::OP_SKIP_RBS, 3'h2, 16'h0, 1'b1, 22'h2);
    jump(bsls_pkg::OP_SKIP_RBC, 3'h0, 16'h0, 1'b1, 22'h2);
  endtask : t_skip
  task automatic t_cmp;
    OP_RD_VAL = 8'h00;
    OP_RR_VAL = 8'h01;
    issue(bsls_pkg::OP_CMP_REGS, 3'h0, 16'h0);
    `CHECK("flags", 8'h35, FLAGS)
    OP_RD_VAL = 8'h02;
    issue(bsls_pkg::OP_CMP_CARRY, 3'h0, 16'h0);
    `CHECK("flags", 8'h00, FLAGS)
    OP_RD_VAL = 8'h20;
    issue(bsls_pkg::OP_CMP_IMM, 3'h0, 16'h0020);
    `CHECK("flags", 8'h02, FLAGS)
    OP_RR_VAL = 8'h20;
    issue(bsls_pkg::OP_CMP_REGS, 3'h0, 16'h0);
    `CHECK("flags", 8'h02, FLAGS)
    issue(bsls_pkg::OP_PAIR_COPY, 3'h0, 16'h0);
    `CHECK("pair", 18'h3beef, {REG_WE, REG_PAIR, REG_WDATA})
  endtask : t_cmp
  task automatic t_mem;
    issue(bsls_pkg::OP_PTR_READ_INC, 3'h1, 16'h0);
    `CHECK("addr", 16'h0100, MEM_ADDR)
    `CHECK("ptr", 18'h10101, {PTR_IDX, PTR_WDATA})
    @(negedge CORE_CLK);
    `CHECK("wdata", 16'h005a, REG_WDATA)
    `CHECK("idx", 5'h10, REG_IDX)
    issue(bsls_pkg::OP_PTR_READ_DEC, 3'h0, 16'h0);
    `CHECK("addr", 16'h007f, MEM_ADDR)
    issue(bsls_pkg::OP_OFS_READ, 3'h2, 16'h0005);
    `CHECK("addr", 16'h0205, MEM_ADDR)
    `CHECK("ptr we", 1'b0, PTR_WE)
    OP_RR_VAL = 8'ha5;
    issue(bsls_pkg::OP_PTR_WRITE_DEC, 3'h2, 16'h0);
    `CHECK("wdata", 8'ha5, MEM_WDATA)
    issue(bsls_pkg::OP_ABS_WRITE, 3'h0, 16'h0456);
    `CHECK("write", 17'h10456, {MEM_WE, MEM_ADDR})
    issue(bsls_pkg::OP_PTR_WRITE_INC, 3'h0, 16'h0);
    `CHECK("write", 33'h100800081, {MEM_WE, MEM_ADDR, PTR_WDATA})
    issue(bsls_pkg::OP_ABS_READ, 3'h0, 16'h1234);
    `CHECK("addr", 16'h1234, MEM_ADDR)
    @(negedge CORE_CLK);
    `CHECK("ready", 1'b0, OP_READY)
  endtask : t_mem
  task automatic t_indirect_call_op;
    PTR_THREE = 16'h1234;
    issue(bsls_pkg::OP_INDIRECT_CALL, 3'h0, 16'h0);
    `CHECK("pc", 22'h001234, PC)
    `CHECK("push addr", 16'h3fff, MEM_ADDR)
    @(negedge CORE_CLK);
    `CHECK("sp", 16'h3ffd, SP)
    issue(bsls_pkg::OP_INT_EXIT, 3'h0, 16'h0);
    repeat (2) @(negedge CORE_CLK);
    `CHECK("pc", 22'h005a5a, PC)
    `CHECK("ret", 18'h13fff, {OP_READY, FLAGS[7], SP})
  endtask : t_indirect_call_op
  initial begin
    repeat (20) @(negedge CORE_CLK);
    RESET = 1'b0;
    `CHECK("pc", 22'h0, PC)
    `CHECK("sp", 16'h3fff, SP)
    t_branch();
    t_skip();
    t_cmp();
    t_mem();
    t_indirect_call_op();
    complete_run();
  end
  // Whole run is some 100 cycles; this allows ample margin
  initial begin
    #20000;
    failures++;
    complete_run();
  end
`undef CHECK
endmodule : branch_skip_load_store_exec_test
`default_nettype wire
